// File: nct_pkg.sv
// Package: constants, opcode map and carrier types of the nibble transfer core
package nct_pkg;
    // ----------------------------------------------------------------
    // Widths and register map
    // ----------------------------------------------------------------
    localparam int PC_W = 13;
    localparam int AXI_AW = 8;
    localparam int DM_AW = 11;
    localparam logic [AXI_AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] ADDR_BANK = 8'h04;
    localparam logic [AXI_AW-1:0] ADDR_PC = 8'h08;
    localparam logic [AXI_AW-1:0] ADDR_REGS = 8'h0c;
    localparam logic [AXI_AW-1:0] ADDR_STAT = 8'h10;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MBE_BIT = 1;
    localparam int CTRL_PCC_LSB = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Machine cycle length in CLK_I periods minus one, per clock setting
    localparam logic [3:0] CPU_DIV_M1 [0:3] = '{4'h7, 4'h3, 4'h1, 4'h0};
    // ----------------------------------------------------------------
    // Banks, pointer wrap values, register indices
    // ----------------------------------------------------------------
    localparam logic [3:0] BANK_ZERO = 4'h0;
    localparam logic [3:0] BANK_TOP = 4'hf;
    localparam logic [3:0] L_WRAP_INC = 4'h0;
    localparam logic [3:0] L_WRAP_DEC = 4'hf;
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_D = 3'h4;
    localparam logic [2:0] REG_E = 3'h5;
    localparam logic [2:0] REG_H = 3'h6;
    localparam logic [2:0] REG_L = 3'h7;
    // ----------------------------------------------------------------
    // Opcode classes (high nibble) and memory sub-codes (low nibble)
    // ----------------------------------------------------------------
    localparam logic [3:0] CLS_MOV_A_IMM = 4'h1;
    localparam logic [3:0] CLS_MOV_IMM = 4'h2;
    localparam logic [3:0] CLS_MOV_MEM = 4'h3;
    localparam logic [3:0] CLS_MOV_REG = 4'h4;
    localparam logic [3:0] CLS_MOV_PAIR = 4'h5;
    localparam logic [3:0] CLS_XCH_MEM = 4'h6;
    localparam logic [3:0] CLS_XCH_REG = 4'h7;
    localparam logic [3:0] CLS_LONG = 4'he;
    localparam logic [3:0] SUB_HL = 4'h0;
    localparam logic [3:0] SUB_HL_INC = 4'h1;
    localparam logic [3:0] SUB_HL_DEC = 4'h2;
    localparam logic [3:0] SUB_DE = 4'h3;
    localparam logic [3:0] SUB_DL = 4'h4;
    localparam logic [3:0] SUB_HL_XA = 4'h5;
    localparam logic [3:0] SUB_ST_HL_A = 4'h6;
    localparam logic [3:0] SUB_ST_HL_XA = 4'h7;
    localparam logic [3:0] SUB_MEM_A = 4'h8;
    localparam logic [3:0] SUB_MEM_XA = 4'h9;
    localparam logic [3:0] SUB_ST_MEM_A = 4'ha;
    localparam logic [3:0] SUB_ST_MEM_XA = 4'hb;
    localparam logic [7:0] OP_MOV_XA_IMM = 8'h28;
    localparam logic [7:0] OP_MOV_HL_IMM = 8'h2b;
    localparam logic [1:0] CNT_1 = 2'h1;
    localparam logic [1:0] CNT_2 = 2'h2;
    localparam logic [1:0] CNT_3 = 2'h3;
    localparam logic [1:0] STR_NONE = 2'h0;
    localparam logic [1:0] STR_A = 2'h1;
    localparam logic [1:0] STR_B = 2'h2;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {logic [1:0] len; logic [1:0] cyc;} nct_lc_s;
    typedef enum logic [1:0] {PH_EXEC, PH_SKIP, PH_SKIP2} nct_phase_e;
    typedef struct packed {
        logic awvalid; logic [AXI_AW-1:0] awaddr; logic wvalid; logic [31:0] wdata;
        logic [3:0] wstrb; logic bready; logic arvalid; logic [AXI_AW-1:0] araddr;
        logic rready;
    } nct_axi_req_s;
    typedef struct packed {
        logic awready; logic wready; logic bvalid; logic [1:0] bresp; logic arready;
        logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } nct_axi_rsp_s;
    typedef struct packed {logic [DM_AW-1:0] addr; logic [7:0] wdata; logic [1:0] we;} nct_dm_req_s;
    typedef struct packed {
        logic run; logic bank_enable_flag; logic [3:0] bank_select_reg; logic [1:0] cpu_clock_ctrl; logic [3:0] div;
        logic [PC_W-1:0] pc; logic [7:0][3:0] rf; nct_phase_e phase; logic [1:0] cnt;
        logic [7:0] op; logic [1:0] strg;
        logic aw_got; logic [AXI_AW-1:0] awaddr; logic w_got; logic [31:0] wdata;
        logic [3:0] wstrb; logic bvalid; logic [1:0] bresp; logic rvalid;
        logic [31:0] rdata; logic [1:0] rresp;
    } nct_state_s;
    localparam nct_state_s NCT_STATE_RST = '0;

    // Byte length and machine cycle count of an opcode
    function automatic nct_lc_s nct_len_cyc(input logic [7:0] op);
        nct_lc_s r;
        r = '{len: CNT_1, cyc: CNT_1};
        case (op[7:4])
            CLS_MOV_IMM, CLS_MOV_REG, CLS_MOV_PAIR: r = '{len: CNT_2, cyc: CNT_2};
            CLS_MOV_MEM, CLS_XCH_MEM: begin
                if (op[3:0] == SUB_HL_INC || op[3:0] == SUB_HL_DEC) begin
                    r = '{len: CNT_1, cyc: CNT_2};
                end else if (op[3:0] == SUB_HL_XA || op[3:0] == SUB_ST_HL_XA || op[3]) begin
                    r = '{len: CNT_2, cyc: CNT_2};
                end
            end
            CLS_XCH_REG: if (op[3]) r = '{len: CNT_2, cyc: CNT_2};
            CLS_LONG: r = '{len: CNT_3, cyc: CNT_3};
            default: r = '{len: CNT_1, cyc: CNT_1};
        endcase
        return r;
    endfunction
endpackage

// File: nct_core.sv
// Nibble core: transfer/exchange execution, skip timing, bank selection, AXI4-Lite control
`timescale 1ns/1ps
`default_nettype none
module nct_core #(
    parameter int PROG_WORDS = 8192
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire nct_pkg::nct_axi_req_s AXI_REQ_I,
    output var nct_pkg::nct_axi_rsp_s AXI_RSP_O,
    output var logic [nct_pkg::PC_W-1:0] PM_ADDR_O,
    input wire logic [7:0] PM_DATA_I,
    output var nct_pkg::nct_dm_req_s DM_REQ_O,
    input wire logic [7:0] DM_RDATA_I,
    output var logic MCYCLE_O,
    output var logic SKIP_O
);
    import nct_pkg::*;

    nct_state_s s_r;
    nct_state_s s_nxt;
    logic tick, run_tick, is_last, suppress, wide, wr_fire;
    logic [7:0] op;
    logic [3:0] sub, bank_hl, bank_mem, nib, a, x, l_new;
    logic [11:0] nib_addr;
    logic [1:0] grp, lane;
    logic [31:0] wmask, wimg;
    nct_lc_s lc, lc_skip;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] pc, input logic [1:0] inc);
        logic [PC_W:0] sum;
        sum = {1'b0, pc} + {{(PC_W-1){1'b0}}, inc};
        if (sum >= PROG_WORDS[PC_W:0]) begin
            sum = sum - PROG_WORDS[PC_W:0];
        end
        return sum[PC_W-1:0];
    endfunction

    // Only banks 0, 1 and 15 exist; anything else lands on 15
    function automatic logic [3:0] mbs_legal(input logic [3:0] bank_select_reg);
        return (bank_select_reg[3:1] == 3'h0) ? bank_select_reg : BANK_TOP;
    endfunction

    function automatic logic addr_hit(input logic [AXI_AW-1:0] adr);
        return adr == ADDR_CTRL || adr == ADDR_BANK || adr == ADDR_PC || adr == ADDR_REGS
            || adr == ADDR_STAT;
    endfunction

    function automatic logic [31:0] reg_image(input nct_state_s st, input logic [AXI_AW-1:0] adr);
        logic [31:0] img;
        img = 32'h0;
        case (adr)
            ADDR_CTRL: begin
                img[CTRL_RUN_BIT] = st.run;
                img[CTRL_MBE_BIT] = st.bank_enable_flag;
                img[CTRL_PCC_LSB +: 2] = st.cpu_clock_ctrl;
            end
            ADDR_BANK: img[3:0] = st.bank_select_reg;
            ADDR_PC: img[PC_W-1:0] = st.pc;
            ADDR_REGS: img = st.rf;
            ADDR_STAT: img[5:0] = {st.cnt, st.strg, st.phase};
            default: img = 32'h0;
        endcase
        return img;
    endfunction

    generate
        for (genvar i = 0; i < 4; i++) begin : g_mask
            assign wmask[8*i +: 8] = {8{s_r.wstrb[i]}};
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        tick = (s_r.div == 4'h0);
        run_tick = tick && s_r.run;
        op = (s_r.cnt == 2'h0) ? PM_DATA_I : s_r.op;
        sub = op[3:0];
        lc = nct_len_cyc(op);
        lc_skip = nct_len_cyc(PM_DATA_I);
        is_last = (s_r.cnt == lc.cyc - CNT_1);
        a = s_r.rf[REG_A];
        x = s_r.rf[REG_X];
        l_new = s_r.rf[REG_L];
        grp = (op[7:4] == CLS_MOV_A_IMM || op == OP_MOV_XA_IMM) ? STR_A
            : ((op == OP_MOV_HL_IMM) ? STR_B : STR_NONE);
        suppress = (grp != STR_NONE) && (grp == s_r.strg);
        bank_hl = s_r.bank_enable_flag ? mbs_legal(s_r.bank_select_reg) : BANK_ZERO;
        bank_mem = s_r.bank_enable_flag ? mbs_legal(s_r.bank_select_reg) : (PM_DATA_I[7] ? BANK_TOP : BANK_ZERO);
        case (sub)
            SUB_DE: nib_addr = {BANK_ZERO, s_r.rf[REG_D], s_r.rf[REG_E]};
            SUB_DL: nib_addr = {BANK_ZERO, s_r.rf[REG_D], s_r.rf[REG_L]};
            SUB_MEM_A, SUB_MEM_XA, SUB_ST_MEM_A, SUB_ST_MEM_XA: nib_addr = {bank_mem, PM_DATA_I};
            default: nib_addr = {bank_hl, s_r.rf[REG_H], s_r.rf[REG_L]};
        endcase
        wide = (sub == SUB_HL_XA || sub == SUB_ST_HL_XA || sub == SUB_MEM_XA
            || sub == SUB_ST_MEM_XA);
        lane = nib_addr[0] ? 2'h2 : 2'h1;
        nib = nib_addr[0] ? DM_RDATA_I[7:4] : DM_RDATA_I[3:0];
        DM_REQ_O.addr = nib_addr[11:1];
        DM_REQ_O.wdata = wide ? {x, a} : {a, a};
        DM_REQ_O.we = 2'h0;
        s_nxt.div = tick ? CPU_DIV_M1[s_r.cpu_clock_ctrl] : s_r.div - 4'h1;

        // Instruction execution, one step per machine cycle
        if (run_tick && s_r.phase == PH_EXEC) begin
            if (s_r.cnt == 2'h0) begin
                s_nxt.op = PM_DATA_I;
            end
            if (!is_last) begin
                s_nxt.cnt = s_r.cnt + CNT_1;
            end else begin
                s_nxt.cnt = 2'h0;
                s_nxt.pc = pc_add(s_r.pc, lc.len);
                s_nxt.strg = grp;
                if (!suppress) begin
                    case (op[7:4])
                        CLS_MOV_A_IMM: s_nxt.rf[REG_A] = sub;
                        CLS_MOV_IMM: begin
                            if (!sub[3]) begin
                                s_nxt.rf[sub[2:0]] = PM_DATA_I[3:0];
                            end else if (!sub[2]) begin
                                s_nxt.rf[{sub[1:0], 1'b0}] = PM_DATA_I[7:4];
                                s_nxt.rf[{sub[1:0], 1'b1}] = PM_DATA_I[3:0];
                            end
                        end
                        CLS_MOV_MEM: begin
                            case (sub)
                                SUB_HL, SUB_HL_INC, SUB_HL_DEC, SUB_DE, SUB_DL, SUB_MEM_A: begin
                                    s_nxt.rf[REG_A] = nib;
                                end
                                SUB_HL_XA, SUB_MEM_XA: begin
                                    s_nxt.rf[REG_A] = DM_RDATA_I[3:0];
                                    s_nxt.rf[REG_X] = DM_RDATA_I[7:4];
                                end
                                SUB_ST_HL_A, SUB_ST_MEM_A: DM_REQ_O.we = lane;
                                SUB_ST_HL_XA, SUB_ST_MEM_XA: DM_REQ_O.we = 2'h3;
                                default: DM_REQ_O.we = 2'h0;
                            endcase
                        end
                        CLS_XCH_MEM: begin
                            case (sub)
                                SUB_HL, SUB_HL_INC, SUB_HL_DEC, SUB_DE, SUB_DL, SUB_MEM_A: begin
                                    s_nxt.rf[REG_A] = nib;
                                    DM_REQ_O.we = lane;
                                end
                                SUB_HL_XA, SUB_MEM_XA: begin
                                    s_nxt.rf[REG_A] = DM_RDATA_I[3:0];
                                    s_nxt.rf[REG_X] = DM_RDATA_I[7:4];
                                    DM_REQ_O.we = 2'h3;
                                end
                                default: DM_REQ_O.we = 2'h0;
                            endcase
                        end
                        CLS_MOV_REG: begin
                            if (!sub[3]) begin
                                s_nxt.rf[REG_A] = s_r.rf[sub[2:0]];
                            end else begin
                                s_nxt.rf[sub[2:0]] = a;
                            end
                        end
                        CLS_MOV_PAIR: begin
                            if (sub[3:2] == 2'b00) begin
                                s_nxt.rf[REG_X] = s_r.rf[{sub[1:0], 1'b0}];
                                s_nxt.rf[REG_A] = s_r.rf[{sub[1:0], 1'b1}];
                            end else if (sub[3:2] == 2'b01) begin
                                s_nxt.rf[{sub[1:0], 1'b0}] = x;
                                s_nxt.rf[{sub[1:0], 1'b1}] = a;
                            end
                        end
                        CLS_XCH_REG: begin
                            if (!sub[3]) begin
                                s_nxt.rf[sub[2:0]] = a;
                                s_nxt.rf[REG_A] = s_r.rf[sub[2:0]];
                            end else if (!sub[2]) begin
                                s_nxt.rf[{sub[1:0], 1'b0}] = x;
                                s_nxt.rf[{sub[1:0], 1'b1}] = a;
                                s_nxt.rf[REG_X] = s_r.rf[{sub[1:0], 1'b0}];
                                s_nxt.rf[REG_A] = s_r.rf[{sub[1:0], 1'b1}];
                            end
                        end
                        default: DM_REQ_O.we = 2'h0;
                    endcase
                    // Pointer post-step and wrap-driven skip
                    if (op[7:4] == CLS_MOV_MEM || op[7:4] == CLS_XCH_MEM) begin
                        if (sub == SUB_HL_INC) begin
                            l_new = s_r.rf[REG_L] + 4'h1;
                            s_nxt.rf[REG_L] = l_new;
                            if (l_new == L_WRAP_INC) begin
                                s_nxt.phase = PH_SKIP;
                            end
                        end else if (sub == SUB_HL_DEC) begin
                            l_new = s_r.rf[REG_L] - 4'h1;
                            s_nxt.rf[REG_L] = l_new;
                            if (l_new == L_WRAP_DEC) begin
                                s_nxt.phase = PH_SKIP;
                            end
                        end
                    end
                end
            end
        end else if (run_tick && s_r.phase == PH_SKIP) begin
            s_nxt.strg = STR_NONE;
            if (lc_skip.len == CNT_3) begin
                s_nxt.phase = PH_SKIP2;
            end else begin
                s_nxt.pc = pc_add(s_r.pc, lc_skip.len);
                s_nxt.phase = PH_EXEC;
            end
        end else if (run_tick && s_r.phase == PH_SKIP2) begin
            s_nxt.pc = pc_add(s_r.pc, CNT_3);
            s_nxt.phase = PH_EXEC;
        end
        if (!CE_I) begin
            DM_REQ_O.we = 2'h0;
        end

        // ------------------------------------------------------------
        // AXI4-Lite slave
        // ------------------------------------------------------------
        AXI_RSP_O.awready = !s_r.aw_got && !s_r.bvalid;
        AXI_RSP_O.wready = !s_r.w_got && !s_r.bvalid;
        AXI_RSP_O.bvalid = s_r.bvalid;
        AXI_RSP_O.bresp = s_r.bresp;
        AXI_RSP_O.arready = !s_r.rvalid;
        AXI_RSP_O.rvalid = s_r.rvalid;
        AXI_RSP_O.rdata = s_r.rdata;
        AXI_RSP_O.rresp = s_r.rresp;
        if (AXI_REQ_I.awvalid && AXI_RSP_O.awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = AXI_REQ_I.awaddr;
        end
        if (AXI_REQ_I.wvalid && AXI_RSP_O.wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = AXI_REQ_I.wdata;
            s_nxt.wstrb = AXI_REQ_I.wstrb;
        end
        if (s_r.bvalid && AXI_REQ_I.bready) begin
            s_nxt.bvalid = 1'b0;
        end
        wr_fire = s_r.aw_got && s_r.w_got;
        wimg = (reg_image(s_r, s_r.awaddr) & ~wmask) | (s_r.wdata & wmask);
        if (wr_fire) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = addr_hit(s_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_r.awaddr)
                ADDR_CTRL: begin
                    s_nxt.run = wimg[CTRL_RUN_BIT];
                    s_nxt.bank_enable_flag = wimg[CTRL_MBE_BIT];
                    s_nxt.cpu_clock_ctrl = wimg[CTRL_PCC_LSB +: 2];
                end
                ADDR_BANK: s_nxt.bank_select_reg = wimg[3:0];
                ADDR_PC: begin
                    s_nxt.pc = pc_add(wimg[PC_W-1:0], 2'h0);
                    s_nxt.phase = PH_EXEC;
                    s_nxt.cnt = 2'h0;
                    s_nxt.strg = STR_NONE;
                end
                default: s_nxt.bresp = s_nxt.bresp;
            endcase
        end
        if (s_r.rvalid && AXI_REQ_I.rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (AXI_REQ_I.arvalid && AXI_RSP_O.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = reg_image(s_r, AXI_REQ_I.araddr);
            s_nxt.rresp = addr_hit(AXI_REQ_I.araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        PM_ADDR_O = pc_add(s_r.pc, s_r.cnt);
        MCYCLE_O = run_tick && CE_I;
        SKIP_O = (s_r.phase != PH_EXEC);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s_r <= NCT_STATE_RST;
        end else if (CE_I) begin
            s_r <= s_nxt;
        end
    end
endmodule // nct_core
`default_nettype wire

// File: nct_core_asserts.sv
// Checker: port properties of the nibble core
`timescale 1ns/1ps
`default_nettype none
module nct_core_chk
    import nct_pkg::*;
#(
    parameter int PROG_WORDS = 8192
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire nct_axi_req_s AXI_REQ_I,
    input wire nct_axi_rsp_s AXI_RSP_O,
    input wire logic [PC_W-1:0] PM_ADDR_O,
    input wire logic [7:0] PM_DATA_I,
    input wire nct_dm_req_s DM_REQ_O,
    input wire logic [7:0] DM_RDATA_I,
    input wire logic MCYCLE_O,
    input wire logic SKIP_O
);
    // ----------------------------------------
    // Skip tracking and properties
    // ----------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic skip_prev_r;
    always_ff @(posedge CLK_I) begin
        if (RST_I) skip_prev_r <= 1'b0;
        else if (MCYCLE_O) skip_prev_r <= SKIP_O;
    end
    sequence s_skip_first;
        MCYCLE_O && SKIP_O && !skip_prev_r;
    endsequence
    sequence s_exec_op(logic [7:0] a, logic [7:0] b);
        MCYCLE_O && !SKIP_O && (PM_DATA_I == a || PM_DATA_I == b);
    endsequence
    a_pair_bank0: assert property (s_exec_op(8'h33, 8'h34) |->
        DM_REQ_O.addr[10:7] == BANK_ZERO) else $error("pair access left bank zero");
    a_skip_starts: assert property ($rose(SKIP_O) |-> $past(MCYCLE_O))
        else $error("skip began inside a machine cycle");
    a_skip_short: assert property (s_skip_first ##0 (PM_DATA_I[7:4] != CLS_LONG)
        |=> !SKIP_O) else $error("short skip took more than one cycle");
    a_skip_long: assert property (s_skip_first ##0 (PM_DATA_I[7:4] == CLS_LONG)
        |=> SKIP_O) else $error("long skip took one cycle");
    a_skip_ends: assert property (MCYCLE_O && SKIP_O && skip_prev_r |=> !SKIP_O)
        else $error("skip ran past two cycles");
    a_skip_nowrite: assert property (SKIP_O |-> DM_REQ_O.we == 2'h0)
        else $error("skipped instruction wrote memory");
    a_we_at_end: assert property (DM_REQ_O.we != 2'h0 |-> MCYCLE_O && CE_I)
        else $error("write outside machine cycle end");
    a_pm_steady: assert property (!MCYCLE_O && !AXI_RSP_O.bvalid |=>
        $stable(PM_ADDR_O) || AXI_RSP_O.bvalid) else $error("fetch address moved mid cycle");
    a_xch_writes: assert property (s_exec_op(8'h61, 8'h62) |->
        ##[1:8] (MCYCLE_O && DM_REQ_O.we != 2'h0)) else $error("exchange did not write");
endmodule // nct_core_chk
bind nct_core nct_core_chk #(.PROG_WORDS(PROG_WORDS)) nct_core_chk_i (.CLK_I(CLK_I),
    .RST_I(RST_I), .CE_I(CE_I), .AXI_REQ_I(AXI_REQ_I), .AXI_RSP_O(AXI_RSP_O),
    .PM_ADDR_O(PM_ADDR_O), .PM_DATA_I(PM_DATA_I), .DM_REQ_O(DM_REQ_O),
    .DM_RDATA_I(DM_RDATA_I), .MCYCLE_O(MCYCLE_O), .SKIP_O(SKIP_O));
`default_nettype wire

// File: nct_core_test.sv
// Testbench: AXI4-Lite driven tests of the nibble core
`timescale 1ns/1ps
`default_nettype none
module nct_core_test;
    import nct_pkg::*;
    // ----------------------------------------
    // Design, memories and counters
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    nct_axi_req_s req = '0;
    nct_axi_rsp_s rsp;
    logic [PC_W-1:0] pm_addr;
    nct_dm_req_s dm_req;
    logic mcyc;
    logic skip;
    logic [7:0] pm [0:8191];
    logic [7:0] dm [0:2047];
    logic [7:0] prog [0:13] = '{8'h2b, 8'h0f, 8'h31, 8'h15, 8'h32, 8'he0, 8'h00, 8'h00,
        8'h61, 8'h1a, 8'h62, 8'hf0, 8'h17, 8'h19};
    int fails = 0;
    int checks_done = 0;
    int mcyc_n = 0;
    int skip_n = 0;
    int m0;
    logic [1:0] resp;
    logic [31:0] rd;
    always #20 clk = ~clk;
    nct_core nct_core_i (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .AXI_REQ_I(req),
        .AXI_RSP_O(rsp), .PM_ADDR_O(pm_addr), .PM_DATA_I(pm[pm_addr]), .DM_REQ_O(dm_req),
        .DM_RDATA_I(dm[dm_req.addr]), .MCYCLE_O(mcyc), .SKIP_O(skip));
    always @(posedge clk) begin
        if (dm_req.we[0]) dm[dm_req.addr][3:0] <= dm_req.wdata[3:0];
        if (dm_req.we[1]) dm[dm_req.addr][7:4] <= dm_req.wdata[7:4];
        if (mcyc) mcyc_n <= mcyc_n + 1;
        if (mcyc && skip) skip_n <= skip_n + 1;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(negedge clk);
            aw = req.awvalid && rsp.awready;
            w = req.wvalid && rsp.wready;
            @(posedge clk);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
        end while ((req.awvalid && !aw) || (req.wvalid && !w));
        do @(negedge clk); while (!rsp.bvalid);
        resp = rsp.bresp;
        @(posedge clk);
        req.bready <= 1'b0;
    endtask
    task automatic rdw(input logic [7:0] a);
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do @(negedge clk); while (!rsp.arready);
        @(posedge clk);
        req.arvalid <= 1'b0;
        do @(negedge clk); while (!rsp.rvalid);
        rd = rsp.rdata;
        resp = rsp.rresp;
        @(posedge clk);
        req.rready <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        foreach (pm[i]) pm[i] = 8'h00;
        foreach (dm[i]) dm[i] = 8'h00;
        foreach (prog[i]) pm[i] = prog[i];
        pm[256] = 8'h33;
        pm[257] = 8'h30;
        dm[0] = 8'ha3;
        dm[7] = 8'h5c;
        dm[135] = 8'h9d;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdw(ADDR_CTRL);
        chk("ctrl reset", 32'h0, rd);
        rdw(ADDR_BANK);
        chk("bank reset", 32'h0, rd);
        rdw(8'h40);
        chk("unmapped read", 32'(RESP_SLVERR), 32'(resp));
        wr(8'h40, 32'h1);
        chk("unmapped write", 32'(RESP_SLVERR), 32'(resp));
        $display("test registers done");
        m0 = skip_n;
        wr(ADDR_CTRL, 32'h31);
        repeat (40) @(posedge clk);
        rdw(ADDR_REGS);
        chk("regs after moves", 32'hf000_0070, rd);
        chk("data byte 0", 32'ha5, 32'(dm[0]));
        chk("data byte 7", 32'h3c, 32'(dm[7]));
        chk("skip cycles", 32'd5, 32'(skip_n - m0));
        $display("test transfers done");
        wr(ADDR_BANK, 32'h1);
        wr(ADDR_CTRL, 32'h33);
        wr(ADDR_PC, 32'h100);
        repeat (10) @(posedge clk);
        rdw(ADDR_REGS);
        chk("regs after bank reads", 32'hf000_0090, rd);
        rdw(ADDR_BANK);
        chk("bank select", 32'h1, rd);
        $display("test banks done");
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_CTRL, 32'(1 + (p << CTRL_PCC_LSB)));
            repeat (16) @(posedge clk);
            m0 = mcyc_n;
            repeat (80) @(posedge clk);
            chk("machine cycles", 32'(80 >> (3 - p)), 32'(mcyc_n - m0));
        end
        $display("test clock select done");
        ce <= 1'b0;
        @(posedge clk);
        m0 = mcyc_n;
        repeat (20) @(posedge clk);
        chk("frozen cycles", 32'h0, 32'(mcyc_n - m0));
        ce <= 1'b1;
        repeat (8) @(posedge clk);
        chk("cycles resume", 32'd1, 32'(mcyc_n > m0));
        $display("test clock enable done");
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule // nct_core_test
`default_nettype wire
